// ===== design/fir_coef_regs.vh
`ifndef FIR_COEF_REGS_VH
`define FIR_COEF_REGS_VH

// apb register byte addresses
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_WORD 12'h008

// control register fields
`define CTRL_FLEN_LSB 0
`define CTRL_FLEN_MSB 3
`define CTRL_DL_BIT 4
`define CTRL_RESET 32'h00000000

// status register fields
`define STAT_LOAD_BIT 0
`define STAT_FILL_BIT 1
`define STAT_USER_BIT 2
`define STAT_DLOK_BIT 7
`define STAT_CNT_LSB 8
`define STAT_CNT_MSB 13

// download word fields
`define WORD_ALL_BIT 31
`define WORD_ADR_MSB 30
`define WORD_ADR_LSB 28
`define WORD_COEF_MSB 26
`define WORD_SUM_MSB 15

// filter geometry
`define COEF_W 27
`define HALF_MAX 6'h30
`define COEFS_PER_STEP 6'h06
`define TAP_W 7
`define HALF_W 6
`define FLEN_DEFAULT 4'h0

// fill pace: one unused slot zeroed every FILL_PACE pclk cycles, here every cycle
`define FILL_PACE 2'h1

`endif

// ===== design/coef_ram.v
`timescale 1ns/1ps
// user coefficient store, volatile, registered read
module coef_ram (
	input wire clk,
	input wire wr_en,
	input wire [5:0] wr_addr,
	input wire [26:0] wr_data,
	input wire [5:0] rd_addr,
	output reg [26:0] rd_data
);
	reg [26:0] mem [0:47];

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ===== design/default_coef_rom.v
`timescale 1ns/1ps
// built-in half response, entry 0 next to the centre, sign-magnitude
module default_coef_rom (
	input wire clk,
	input wire [5:0] addr,
	output reg [26:0] data
);
	always @(posedge clk) begin
		case (addr)
			6'h00: data <= 27'h332bca0;
			6'h01: data <= 27'h17fa5a0;
			6'h02: data <= 27'h444a196;
			6'h03: data <= 27'h4b62067;
			6'h04: data <= 27'h4140c31;
			6'h05: data <= 27'h06a734e;
			6'h06: data <= 27'h031dddb;
			6'h07: data <= 27'h439e6b2;
			6'h08: data <= 27'h4392e4a;
			6'h09: data <= 27'h01709d9;
			6'h0a: data <= 27'h0344ef8;
			6'h0b: data <= 27'h001397f;
			6'h0c: data <= 27'h428c5fc;
			6'h0d: data <= 27'h4101f74;
			6'h0e: data <= 27'h01a92fb;
			6'h0f: data <= 27'h016ebf8;
			6'h10: data <= 27'h40cc178;
			6'h11: data <= 27'h4175250;
			6'h12: data <= 27'h0016dba;
			6'h13: data <= 27'h0135efe;
			6'h14: data <= 27'h006466d;
			6'h15: data <= 27'h40d2f26;
			6'h16: data <= 27'h40a242e;
			6'h17: data <= 27'h006a139;
			6'h18: data <= 27'h00ab1af;
			6'h19: data <= 27'h401150a;
			6'h1a: data <= 27'h408e917;
			6'h1b: data <= 27'h402af3e;
			6'h1c: data <= 27'h005ee3b;
			6'h1d: data <= 27'h0047c70;
			6'h1e: data <= 27'h402cbd2;
			6'h1f: data <= 27'h4049e05;
			6'h20: data <= 27'h0003ea2;
			6'h21: data <= 27'h003a2eb;
			6'h22: data <= 27'h00158ca;
			6'h23: data <= 27'h4022f65;
			6'h24: data <= 27'h401f797;
			6'h25: data <= 27'h000ca52;
			6'h26: data <= 27'h001dc13;
			6'h27: data <= 27'h000402a;
			6'h28: data <= 27'h401619c;
			6'h29: data <= 27'h400f99b;
			6'h2a: data <= 27'h000b0b2;
			6'h2b: data <= 27'h001c020;
			6'h2c: data <= 27'h0018fd5;
			6'h2d: data <= 27'h000cdbd;
			6'h2e: data <= 27'h0003cc7;
			6'h2f: data <= 27'h00007ab;
			default: data <= 27'h0000000;
		endcase
	end
endmodule

// ===== design/fir_coefficient_download.v
// How it works
// - reset selects the built-in coefficient set
// - default: 96 taps from 48 half coefficients
// - coefficient is 27-bit sign-magnitude
// - half sent, mirrored half derived here
// - coefficients arrive centre first, then outward
// - word: all, address, zero, sign, magnitude
// - targeted word accepted on strap match
// - all flag with zero address: everyone accepts
// - checksum is 16-bit sum of all bytes
// - internal sum match sets download success
// - user set volatile, lost at reset
// - length code: 0 default, odd codes 6..48
// - unused slots zero-filled after checksum
// - success flag at status bit 7
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "fir_coef_regs.vh"

module fir_coefficient_download (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [2:0] device_address_strap,
	input wire [6:0] tap_index,
	output reg [26:0] tap_coef,
	output reg download_success_flag
);
	localparam ST_IDLE = 2'd0;
	localparam ST_LOAD = 2'd1;
	localparam ST_FILL = 2'd2;

	// half-set size for a length code
	function [5:0] half_count;
		input [3:0] code;
		begin
			if (code == `FLEN_DEFAULT) begin
				half_count = `HALF_MAX;
			end else begin
				half_count = ({3'h0, code[3:1]} + 6'h01) * `COEFS_PER_STEP;
			end
		end
	endfunction

	// byte sum of one word, widened to the checksum width
	function [15:0] byte_sum;
		input [31:0] w;
		begin
			byte_sum = {8'h00, w[31:24]} + {8'h00, w[23:16]}
				+ {8'h00, w[15:8]} + {8'h00, w[7:0]};
		end
	endfunction

	// true when the bus address names the given register
	function reg_hit;
		input [11:0] a;
		input [11:0] r;
		begin
			reg_hit = (a == r);
		end
	endfunction

	reg [1:0] state;
	reg [3:0] filter_length_code;
	reg download_filter_request;
	reg [3:0] active_code;
	reg user_active;
	reg [5:0] count;
	reg [5:0] target;
	reg [15:0] sum;
	reg [1:0] pace;
	reg [2:0] strap_meta;
	reg [2:0] strap_sync;
	reg ram_we;
	reg [5:0] ram_wa;
	reg [26:0] ram_wd;
	reg sel_user;
	reg tap_valid;
	reg [5:0] rd_addr;
	reg rd_ok;
	reg [5:0] active_half;
	reg [31:0] next_prdata;
	reg addr_ok;

	wire setup = psel & ~penable;
	wire wr_done = psel & penable & pready & pwrite;
	wire [31:0] status_word;
	wire word_wr;
	wire [2:0] word_adr;
	wire word_match;
	wire [26:0] ram_q;
	wire [26:0] rom_q;
	wire loading;
	wire ctrl_wr;
	wire dl_start;
	wire coef_take;
	wire sum_take;

	assign word_wr = wr_done & ~pslverr & reg_hit(paddr, `REG_WORD);
	assign word_adr = pwdata[`WORD_ADR_MSB:`WORD_ADR_LSB];
	assign word_match = (word_adr == strap_sync)
		| (pwdata[`WORD_ALL_BIT] & (word_adr == 3'h0));

	// write strobes seen by the sequencer
	assign loading = (state == ST_LOAD);
	assign ctrl_wr = wr_done & ~pslverr & reg_hit(paddr, `REG_CTRL)
		& (state != ST_FILL);
	assign dl_start = ctrl_wr & pwdata[`CTRL_DL_BIT];
	assign coef_take = loading & word_wr & word_match & (count != target);
	assign sum_take = loading & word_wr & word_match & (count == target);

	assign status_word = {18'h0, count, download_success_flag, 4'h0,
		user_active, state == ST_FILL, state == ST_LOAD};

	// strap pins are asynchronous, two stages before use
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_meta <= 3'h0;
			strap_sync <= 3'h0;
		end else begin
			strap_meta <= device_address_strap;
			strap_sync <= strap_meta;
		end
	end

	// apb answer: pready one cycle after setup, data caught in setup
	always @* begin
		addr_ok = reg_hit(paddr, `REG_CTRL) | reg_hit(paddr, `REG_STATUS)
			| reg_hit(paddr, `REG_WORD);
		case (paddr)
			`REG_CTRL: next_prdata = {27'h0, download_filter_request,
				filter_length_code};
			`REG_STATUS: next_prdata = status_word;
			default: next_prdata = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= ~addr_ok;
				prdata <= pwrite ? 32'h00000000 : next_prdata;
			end else if (pready) begin
				pslverr <= 1'b0;
				prdata <= 32'h00000000;
			end
		end
	end

	// control register; the request bit drops once the checksum lands
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_length_code <= `FLEN_DEFAULT;
			download_filter_request <= 1'b0;
		end else if (ctrl_wr) begin
			filter_length_code <= pwdata[`CTRL_FLEN_MSB:`CTRL_FLEN_LSB];
			download_filter_request <= pwdata[`CTRL_DL_BIT];
		end else if (sum_take) begin
			download_filter_request <= 1'b0;
		end
	end

	// running byte sum of accepted coefficient words
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum <= 16'h0000;
		end else if (dl_start) begin
			sum <= 16'h0000;
		end else if (coef_take) begin
			sum <= sum + byte_sum(pwdata);
		end
	end

	// success flag: cleared by a new download, set only on a sum match
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			download_success_flag <= 1'b0;
		end else if (dl_start) begin
			download_success_flag <= 1'b0;
		end else if (sum_take) begin
			download_success_flag <= (pwdata[`WORD_SUM_MSB:0] == sum);
		end
	end

	// download sequencer: load, checksum, zero fill
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_code <= `FLEN_DEFAULT;
			user_active <= 1'b0;
			state <= ST_IDLE;
			count <= 6'h00;
			target <= 6'h00;
			pace <= 2'h0;
			ram_we <= 1'b0;
			ram_wa <= 6'h00;
			ram_wd <= 27'h0;
		end else begin
			ram_we <= 1'b0;
			if (dl_start) begin
				// a fresh download drops the old user set
				state <= ST_LOAD;
				count <= 6'h00;
				target <= half_count(pwdata[`CTRL_FLEN_MSB:`CTRL_FLEN_LSB]);
				active_code <= pwdata[`CTRL_FLEN_MSB:`CTRL_FLEN_LSB];
				user_active <= 1'b0;
			end else begin
				case (state)
					ST_LOAD: begin
						if (coef_take) begin
							ram_we <= 1'b1;
							ram_wa <= count;
							ram_wd <= pwdata[`WORD_COEF_MSB:0];
							count <= count + 6'h01;
						end else if (sum_take) begin
							// checksum word closes the download
							pace <= 2'h0;
							state <= ST_FILL;
						end
					end
					ST_FILL: begin
						if (count == `HALF_MAX) begin
							user_active <= 1'b1;
							state <= ST_IDLE;
						end else if (pace == `FILL_PACE - 2'h1) begin
							pace <= 2'h0;
							ram_we <= 1'b1;
							ram_wa <= count;
							ram_wd <= 27'h0;
							count <= count + 6'h01;
						end else begin
							pace <= pace + 2'h1;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// tap to half-set mapping, mirrored around the centre
	always @* begin
		active_half = user_active ? half_count(active_code) : `HALF_MAX;
		rd_ok = 1'b1;
		rd_addr = 6'h00;
		if (tap_index < {active_half, 1'b0}) begin
			if (tap_index < {1'b0, active_half}) begin
				rd_addr = active_half - 6'h01 - tap_index[5:0];
			end else begin
				rd_addr = tap_index[5:0] - active_half;
			end
		end else begin
			rd_ok = 1'b0;
		end
	end

	// tap output, two cycles after the index
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_user <= 1'b0;
			tap_valid <= 1'b0;
			tap_coef <= 27'h0;
		end else begin
			sel_user <= user_active;
			tap_valid <= rd_ok;
			if (!tap_valid) begin
				tap_coef <= 27'h0;
			end else begin
				tap_coef <= sel_user ? ram_q : rom_q;
			end
		end
	end

	// user set, written during load and fill
	coef_ram u_ram (
		.clk(pclk),
		.wr_en(ram_we),
		.wr_addr(ram_wa),
		.wr_data(ram_wd),
		.rd_addr(rd_addr),
		.rd_data(ram_q)
	);

	// built-in set
	default_coef_rom u_rom (
		.clk(pclk),
		.addr(rd_addr),
		.data(rom_q)
	);
endmodule

// ===== dv/fir_coef_props.sv
`timescale 1ns/1ps
module fir_coef_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [6:0] tap_index,
	input wire [26:0] tap_coef,
	input wire download_success_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready too long");
	a_read_idle_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_flag_in_status: assert property (pready && !pwrite && paddr == 12'h004
		|-> prdata[7] == download_success_flag)
		else $error("status bit 7 differs from flag");
	a_flag_steady: assert property ((!(psel && pwrite))[*3]
		|=> $stable(download_success_flag))
		else $error("flag moved without a write");
	a_flag_after_reset: assert property ($rose(presetn) |-> !download_success_flag)
		else $error("flag set after reset");
	a_err_unmapped: assert property (pready |-> pslverr == !(paddr == 12'h000
		|| paddr == 12'h004 || paddr == 12'h008))
		else $error("wrong error response");
	a_tap_beyond: assert property ((tap_index > 7'd95)[*3] |-> tap_coef == 27'h0)
		else $error("tap beyond length not zero");
endmodule
bind fir_coefficient_download fir_coef_props chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tap_index(tap_index), .tap_coef(tap_coef),
	.download_success_flag(download_success_flag));

// ===== dv/apb_host.sv
`timescale 1ns/1ps
module apb_host (
	input logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr
);
	int hung;
	initial begin
		hung = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
	end
	// one transfer, held until ready is sampled
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		begin
			n = 0;
			@(posedge pclk);
			psel <= 1;
			penable <= 0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 20) begin
				n++;
				@(posedge pclk);
			end
			r = prdata;
			e = pslverr;
			if (pready !== 1'b1) hung++;
			psel <= 0;
			penable <= 0;
		end
	endtask
endmodule

// ===== dv/test_fir_coefficient_download.sv
`timescale 1ns/1ps
module test_fir_coefficient_download;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flag, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [2:0] strap;
	logic [6:0] tap_index;
	logic [26:0] tap_coef;
	int errors = 0;
	int samples_checked = 0;
	logic [31:0] cw [12] = '{32'h032b9688, 32'h01bf183c, 32'h00156626, 32'h04a81e6a,
		32'h045f2a96, 32'h002c49c2, 32'h0050e9f6, 32'h0010dbd8, 32'h042fde54,
		32'h0437445a, 32'h041b7d6e, 32'h04043b5f};
	apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	fir_coefficient_download uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.device_address_strap(strap), .tap_index(tap_index), .tap_coef(tap_coef),
		.download_success_flag(flag));
	always #50 pclk = ~pclk;
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1, a, d, rv, re);
	endtask
	task rd(input logic [11:0] a);
		host.xfer(0, a, 32'h0, rv, re);
	endtask
	task tp(input logic [6:0] k, input logic [26:0] e);
		@(posedge pclk) tap_index <= k;
		repeat (3) @(posedge pclk);
		chk("tap", {5'h0, tap_coef}, {5'h0, e});
	endtask
	task dl(input logic [3:0] h, input logic [3:0] c, input logic [15:0] bump,
		input logic ok);
		logic [31:0] w;
		logic [15:0] s;
		int n;
		logic acc;
		begin
			s = 0;
			n = (c[3:1] + 1) * 6;
			wr(12'h000, {27'h0, 1'b1, c});
			acc = (h[2:0] == strap) || (h == 4'h8);
			for (int i = 0; i < n; i++) begin
				w = {h, cw[i][27:0]};
				s = s + w[31:24] + w[23:16] + w[15:8] + w[7:0];
				wr(12'h008, w);
			end
			wr(12'h008, {h, 12'h0, s + bump});
			repeat (52 - n) @(posedge pclk);
			rd(12'h004);
			chk("status success", {31'h0, rv[7]}, {31'h0, ok});
			chk("status error", {31'h0, re}, 32'h0);
			chk("flag", {31'h0, flag}, {31'h0, ok});
			rd(12'h000);
			chk("control", rv, {27'h0, !acc, c});
			$display("download test done");
		end
	endtask
	task test_done;
		errors += host.hung;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		pclk = 0;
		presetn = 0;
		strap = 3'h0;
		tap_index = 7'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		rd(12'h004);
		chk("status", rv, 32'h0);
		tp(7'd47, 27'h332bca0);
		tp(7'd48, 27'h332bca0);
		tp(7'd0, 27'h00007ab);
		tp(7'd95, 27'h00007ab);
		tp(7'd100, 27'h0);
		rd(12'h00c);
		chk("unmapped", {31'h0, re}, 32'h1);
		$display("default filter test done");
		dl(4'h0, 4'h3, 16'h0, 1);
		tp(7'd11, 27'h32b9688);
		tp(7'd12, 27'h32b9688);
		tp(7'd0, 27'h4043b5f);
		tp(7'd24, 27'h0);
		rd(12'h004);
		chk("user active", {31'h0, rv[2]}, 32'h1);
		dl(4'h0, 4'h3, 16'h1, 0);
		strap <= 3'h5;
		dl(4'h0, 4'h3, 16'h0, 0);
		dl(4'h5, 4'h3, 16'h0, 1);
		dl(4'h8, 4'h3, 16'h0, 1);
		dl(4'h5, 4'h1, 16'h0, 1);
		tp(7'd5, 27'h32b9688);
		tp(7'd0, 27'h02c49c2);
		tp(7'd12, 27'h0);
		$display("short filter test done");
		presetn <= 0;
		@(posedge pclk) presetn <= 1;
		repeat (2) @(posedge pclk);
		chk("flag reset", {31'h0, flag}, 32'h0);
		tp(7'd47, 27'h332bca0);
		$display("reset test done");
		test_done;
	end
endmodule
